/* verilog/dcpm_pkg.sv */
`default_nettype none
package dcpm_pkg;

    // Clock and timing
    localparam int unsigned CLK_HZ         = 10_000_000;
    localparam int unsigned SLOW_HZ        = 80_000;
    localparam int unsigned SLOW_DIV       = CLK_HZ / SLOW_HZ;
    localparam int unsigned PIN_MIN_SLOW   = 2;
    localparam int unsigned IT_SYS_DIV     = 128;
    localparam int unsigned WDT_BASE_MS    = 128;
    localparam int unsigned WDT_BASE_TICKS = (WDT_BASE_MS * SLOW_HZ) / 1000;

    // Register indices, byte address is four times the index
    localparam logic [9:0] IDX_SYSTEM_CLOCK_CONTROL = 10'h00B;
    localparam logic [9:0] IDX_TRIM   = 10'h18F;
    localparam logic [9:0] IDX_CFG    = 10'h020;
    localparam logic [9:0] IDX_SYSCTL = 10'h021;
    localparam logic [9:0] IDX_STATUS = 10'h022;

    // Reset values
    localparam logic [7:0]  SYSTEM_CLOCK_CONTROL_RST   = 8'h00;
    localparam logic [7:0]  SYSCTL_RST   = 8'h00;
    localparam logic [7:0]  CFG_RST      = 8'h00;
    localparam logic [5:0]  TRIM_RST     = 6'h20;
    localparam logic [10:0] RESET_VECTOR = 11'h000;

    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;
    localparam logic [1:0] WDT_RUN_ALWAYS = 2'h3;

    typedef enum logic [3:0] {
        DCPM_FAST = 4'h1,
        DCPM_SLOW = 4'h2,
        DCPM_IDLE = 4'h4,
        DCPM_STOP = 4'h8
    } dcpm_mode_t;

    typedef struct packed {
        logic       rsv7;
        logic       slow_clk_type;
        logic       fast_clk_type;
        logic       slow_osc_stop;
        logic       fast_osc_stop;
        logic       sysclk_select;
        logic [1:0] rsv_lo;
    } dcpm_system_clock_control_t;

    typedef struct packed {
        logic [2:0] rsv;
        logic [1:0] lvr_select;
        logic [1:0] watchdog_enable_cfg;
        logic       ext_reset_en;
    } dcpm_cfg_t;

    typedef struct packed {
        logic [3:0] rsv;
        logic [1:0] watchdog_prescale;
        logic       wakeup_timer_int_enable;
        logic       interval_timer_clk_select;
    } dcpm_sysctl_t;

    typedef struct packed {
        logic       slow_running;
        logic       fast_running;
        logic       timeout_flag;
        logic       power_down_flag;
        dcpm_mode_t mode;
    } dcpm_status_t;

endpackage
`default_nettype wire

/* verilog/dcpm_pin_filter.sv */
`timescale 1ns/10ps
`default_nettype none
module dcpm_pin_filter #(
    parameter int unsigned MIN_TICKS = dcpm_pkg::PIN_MIN_SLOW
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic pin_n,
    input  wire logic tick,
    input  wire logic enable,
    output logic      rst_req
);
    logic       s1_q;
    logic       s2_q;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;

    // Count slow periods of a continuously low pin
    always_comb
    begin
        cnt_d = cnt_q;
        if (s2_q || !enable)
            cnt_d = 4'h0;
        else if (tick && (cnt_q < 4'(MIN_TICKS)))
            cnt_d = cnt_q + 4'h1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1_q  <= 1'b1;
            s2_q  <= 1'b1;
            cnt_q <= 4'h0;
        end
        else
        begin
            s1_q  <= pin_n;
            s2_q  <= s1_q;
            cnt_q <= cnt_d;
        end
    end

    assign rst_req = enable && (cnt_q >= 4'(MIN_TICKS));
endmodule
`default_nettype wire

/* verilog/dcpm_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module dcpm_ctrl #(
    parameter int unsigned WDT_BASE_TICKS = dcpm_pkg::WDT_BASE_TICKS
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic [3:0]  lv_below,
    input  wire logic        ext_reset_pin_n,
    input  wire logic        sleep_instr,
    input  wire logic        watchdog_clear_instr,
    input  wire logic        bank_select_bit0,
    input  wire logic        ext_int_wake,
    input  wire logic        wakeup_timer_int,
    input  wire logic        timer_int_wake,
    output logic             sys_reset,
    output logic [10:0]      pc_reset_vector,
    output logic             fast_osc_en,
    output logic             slow_osc_en,
    output logic [5:0]       fast_rc_trim,
    output logic             fsys_en,
    output logic             periph_clk_en,
    output logic             interval_timer_clk_en,
    output logic             cpu_run,
    output logic [3:0]       mode,
    output logic             timeout_flag,
    output logic             power_down_flag
);
    localparam int unsigned WDT_W = 18;

    dcpm_pkg::dcpm_mode_t   mode_q, mode_d;
    dcpm_pkg::dcpm_system_clock_control_t system_clock_control_q, system_clock_control_d;
    dcpm_pkg::dcpm_cfg_t    cfg_q, cfg_d;
    dcpm_pkg::dcpm_sysctl_t sysctl_q, sysctl_d;
    dcpm_pkg::dcpm_status_t status;
    logic [5:0]       trim_q, trim_d;
    logic             to_q, to_d, pd_q, pd_d;
    logic [6:0]       slow_div_q, slow_div_d;
    logic [6:0]       it_div_q, it_div_d;
    logic [WDT_W-1:0] wdt_q, wdt_d;
    logic             wdt_ovf_q, wdt_ovf_d;
    logic             sys_rst_q, sys_rst_d;
    logic             fast_en_q, fast_en_d, slow_en_q, slow_en_d;
    logic [3:0]       lvr_s1_q, lvr_s2_q;
    logic             aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [9:0]       aw_idx_q, aw_idx_d;
    logic [7:0]       wbyte_q, wbyte_d;
    logic             wlane_q, wlane_d;
    logic             bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0]       bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0]      rdata_q, rdata_d;
    logic             wr_fire, slow_ref, slow_tick, lvr_act, pin_rst, sleep_ok, wake, wdt_run;

    function automatic logic reg_hit(input logic [9:0] idx);
        reg_hit = (idx == dcpm_pkg::IDX_SYSTEM_CLOCK_CONTROL) || (idx == dcpm_pkg::IDX_TRIM) ||
                  (idx == dcpm_pkg::IDX_CFG) || (idx == dcpm_pkg::IDX_SYSCTL) ||
                  (idx == dcpm_pkg::IDX_STATUS);
    endfunction

    function automatic logic [WDT_W-1:0] wdt_limit(input logic [1:0] psc);
        logic [WDT_W-1:0] base;
        base = WDT_W'(WDT_BASE_TICKS);
        case (psc)
            2'h0:    wdt_limit = base;
            2'h1:    wdt_limit = base << 1;
            2'h2:    wdt_limit = base << 3;
            default: wdt_limit = base << 4;
        endcase
    endfunction

    // Blocks abnormal clock-control settings
    function automatic dcpm_pkg::dcpm_system_clock_control_t clk_filter(input dcpm_pkg::dcpm_system_clock_control_t old,
                                                         input dcpm_pkg::dcpm_system_clock_control_t nw,
                                                         input dcpm_pkg::dcpm_mode_t m);
        dcpm_pkg::dcpm_system_clock_control_t r;
        r        = nw;
        r.rsv7   = 1'b0;
        r.rsv_lo = 2'h0;
        if (m != dcpm_pkg::DCPM_FAST)
            r.slow_clk_type = old.slow_clk_type;
        if (m != dcpm_pkg::DCPM_SLOW)
            r.fast_clk_type = old.fast_clk_type;
        if (m == dcpm_pkg::DCPM_FAST && nw.fast_osc_stop)
            r.fast_osc_stop = old.fast_osc_stop;
        if (m == dcpm_pkg::DCPM_SLOW && nw.slow_osc_stop)
            r.slow_osc_stop = old.slow_osc_stop;
        if (nw.sysclk_select && !old.sysclk_select && old.fast_osc_stop)
            r.sysclk_select = 1'b0;
        if (!nw.sysclk_select && old.sysclk_select && old.slow_osc_stop)
            r.sysclk_select = 1'b1;
        if (nw.fast_osc_stop && nw.sysclk_select)
            r = old;
        clk_filter = r;
    endfunction

    dcpm_pin_filter #(
        .MIN_TICKS (dcpm_pkg::PIN_MIN_SLOW)
    ) u_pin_filter (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin_n   (ext_reset_pin_n),
        .tick    (slow_ref),
        .enable  (cfg_q.ext_reset_en),
        .rst_req (pin_rst)
    );

    assign status = '{slow_running: slow_en_q, fast_running: fast_en_q, timeout_flag: to_q,
                      power_down_flag: pd_q, mode: mode_q};

    // Register bus
    assign awready = !aw_have_q && !bvalid_q;
    assign wready  = !w_have_q && !bvalid_q;
    assign arready = !rvalid_q;
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

    always_comb
    begin
        aw_have_d = aw_have_q;
        aw_idx_d  = aw_idx_q;
        w_have_d  = w_have_q;
        wbyte_d   = wbyte_q;
        wlane_d   = wlane_q;
        bvalid_d  = bvalid_q && !bready;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q && !rready;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        if (awvalid && awready)
        begin
            aw_have_d = 1'b1;
            aw_idx_d  = awaddr[11:2];
        end
        if (wvalid && wready)
        begin
            w_have_d = 1'b1;
            wbyte_d  = wdata[7:0];
            wlane_d  = wstrb[0];
        end
        if (wr_fire)
        begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = reg_hit(aw_idx_q) ? dcpm_pkg::RESP_OKAY : dcpm_pkg::RESP_SLVERR;
        end
        if (arvalid && arready)
        begin
            rvalid_d = 1'b1;
            rresp_d  = reg_hit(araddr[11:2]) ? dcpm_pkg::RESP_OKAY : dcpm_pkg::RESP_SLVERR;
            case (araddr[11:2])
                dcpm_pkg::IDX_SYSTEM_CLOCK_CONTROL: rdata_d = {24'h000000, system_clock_control_q};
                dcpm_pkg::IDX_TRIM:   rdata_d = {26'h0000000, trim_q};
                dcpm_pkg::IDX_CFG:    rdata_d = {24'h000000, cfg_q};
                dcpm_pkg::IDX_SYSCTL: rdata_d = {24'h000000, sysctl_q};
                dcpm_pkg::IDX_STATUS: rdata_d = {24'h000000, status};
                default:              rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            aw_idx_q  <= 10'h000;
            w_have_q  <= 1'b0;
            wbyte_q   <= 8'h00;
            wlane_q   <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
            rvalid_q  <= 1'b0;
            rresp_q   <= 2'h0;
            rdata_q   <= 32'h00000000;
        end
        else
        begin
            aw_have_q <= aw_have_d;
            aw_idx_q  <= aw_idx_d;
            w_have_q  <= w_have_d;
            wbyte_q   <= wbyte_d;
            wlane_q   <= wlane_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
        end
    end

    assign bvalid = bvalid_q;
    assign bresp  = bresp_q;
    assign rvalid = rvalid_q;
    assign rresp  = rresp_q;
    assign rdata  = rdata_q;

    // Clock, mode, reset and watchdog control
    assign slow_ref  = (slow_div_q == 7'(dcpm_pkg::SLOW_DIV - 1));
    assign slow_tick = slow_ref && slow_en_q;
    assign lvr_act   = lvr_s2_q[cfg_q.lvr_select];
    assign sleep_ok  = sleep_instr && !bank_select_bit0 &&
                       (mode_q == dcpm_pkg::DCPM_FAST || mode_q == dcpm_pkg::DCPM_SLOW);
    assign wake      = (mode_q == dcpm_pkg::DCPM_STOP) ? ext_int_wake :
                       (ext_int_wake || wakeup_timer_int || timer_int_wake);
    assign wdt_run   = cfg_q.watchdog_enable_cfg[1] &&
                       (mode_q == dcpm_pkg::DCPM_FAST || mode_q == dcpm_pkg::DCPM_SLOW ||
                        cfg_q.watchdog_enable_cfg == dcpm_pkg::WDT_RUN_ALWAYS);

    always_comb
    begin
        mode_d     = mode_q;
        system_clock_control_d   = system_clock_control_q;
        trim_d     = trim_q;
        cfg_d      = cfg_q;
        sysctl_d   = sysctl_q;
        to_d       = to_q;
        pd_d       = pd_q;
        wdt_d      = wdt_q;
        wdt_ovf_d  = 1'b0;
        slow_div_d = slow_ref ? 7'h00 : slow_div_q + 7'h01;
        it_div_d   = it_div_q;
        sys_rst_d  = lvr_act || pin_rst || wdt_ovf_q;
        if (fsys_en)
            it_div_d = (it_div_q == 7'(dcpm_pkg::IT_SYS_DIV - 1)) ? 7'h00 : it_div_q + 7'h01;
        if (wr_fire && wlane_q)
        begin
            case (aw_idx_q)
                dcpm_pkg::IDX_SYSTEM_CLOCK_CONTROL: system_clock_control_d = clk_filter(system_clock_control_q, wbyte_q, mode_q);
                dcpm_pkg::IDX_TRIM:   trim_d   = wbyte_q[5:0];
                dcpm_pkg::IDX_CFG:    cfg_d    = {3'h0, wbyte_q[4:0]};
                dcpm_pkg::IDX_SYSCTL: sysctl_d = {4'h0, wbyte_q[3:0]};
                default:              ;
            endcase
        end
        case (mode_q)
            dcpm_pkg::DCPM_FAST: if (!system_clock_control_q.sysclk_select) mode_d = dcpm_pkg::DCPM_SLOW;
            dcpm_pkg::DCPM_SLOW: if (system_clock_control_q.sysclk_select) mode_d = dcpm_pkg::DCPM_FAST;
            dcpm_pkg::DCPM_IDLE, dcpm_pkg::DCPM_STOP:
                if (wake)
                    mode_d = system_clock_control_q.sysclk_select ? dcpm_pkg::DCPM_FAST : dcpm_pkg::DCPM_SLOW;
            default: mode_d = dcpm_pkg::DCPM_SLOW;
        endcase
        if (sleep_ok)
        begin
            if ((!system_clock_control_q.slow_osc_stop && !sysctl_q.interval_timer_clk_select) ||
                sysctl_q.wakeup_timer_int_enable ||
                (cfg_q.watchdog_enable_cfg == dcpm_pkg::WDT_RUN_ALWAYS) || !system_clock_control_q.slow_osc_stop)
                mode_d = dcpm_pkg::DCPM_IDLE;
            else
                mode_d = dcpm_pkg::DCPM_STOP;
        end
        if (wdt_run && slow_ref)
        begin
            if (wdt_q == wdt_limit(sysctl_q.watchdog_prescale) - WDT_W'(1))
            begin
                wdt_d     = '0;
                wdt_ovf_d = 1'b1;
            end
            else
                wdt_d = wdt_q + WDT_W'(1);
        end
        if (watchdog_clear_instr || sys_rst_q)
            wdt_d = '0;
        if (watchdog_clear_instr)
        begin
            to_d = 1'b0;
            pd_d = 1'b0;
        end
        if (sleep_ok)
        begin
            to_d = 1'b0;
            pd_d = 1'b1;
        end
        if (wdt_ovf_q)
            to_d = 1'b1;
        if (lvr_act)
        begin
            to_d = 1'b0;
            pd_d = 1'b0;
        end
        if (sys_rst_q)
        begin
            mode_d    = dcpm_pkg::DCPM_SLOW;
            system_clock_control_d  = dcpm_pkg::SYSTEM_CLOCK_CONTROL_RST;
            sysctl_d  = dcpm_pkg::SYSCTL_RST;
            trim_d    = dcpm_pkg::TRIM_RST;
            it_div_d  = 7'h00;
            wdt_ovf_d = 1'b0;
        end
        fast_en_d = (mode_d == dcpm_pkg::DCPM_FAST) ||
                    (mode_d == dcpm_pkg::DCPM_SLOW && !system_clock_control_d.fast_osc_stop);
        slow_en_d = (mode_d == dcpm_pkg::DCPM_SLOW) || (mode_d == dcpm_pkg::DCPM_IDLE) ||
                    (mode_d == dcpm_pkg::DCPM_FAST && !system_clock_control_d.slow_osc_stop);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_q     <= dcpm_pkg::DCPM_SLOW;
            system_clock_control_q   <= dcpm_pkg::SYSTEM_CLOCK_CONTROL_RST;
            trim_q     <= dcpm_pkg::TRIM_RST;
            cfg_q      <= dcpm_pkg::CFG_RST;
            sysctl_q   <= dcpm_pkg::SYSCTL_RST;
            to_q       <= 1'b0;
            pd_q       <= 1'b0;
            wdt_q      <= '0;
            wdt_ovf_q  <= 1'b0;
            slow_div_q <= 7'h00;
            it_div_q   <= 7'h00;
            sys_rst_q  <= 1'b1;
            fast_en_q  <= 1'b0;
            slow_en_q  <= 1'b1;
            lvr_s1_q   <= 4'h0;
            lvr_s2_q   <= 4'h0;
        end
        else
        begin
            mode_q     <= mode_d;
            system_clock_control_q   <= system_clock_control_d;
            trim_q     <= trim_d;
            cfg_q      <= cfg_d;
            sysctl_q   <= sysctl_d;
            to_q       <= to_d;
            pd_q       <= pd_d;
            wdt_q      <= wdt_d;
            wdt_ovf_q  <= wdt_ovf_d;
            slow_div_q <= slow_div_d;
            it_div_q   <= it_div_d;
            sys_rst_q  <= sys_rst_d;
            fast_en_q  <= fast_en_d;
            slow_en_q  <= slow_en_d;
            lvr_s1_q   <= lv_below;
            lvr_s2_q   <= lvr_s1_q;
        end
    end

    assign sys_reset       = sys_rst_q;
    assign pc_reset_vector = dcpm_pkg::RESET_VECTOR;
    assign fast_osc_en     = fast_en_q;
    assign slow_osc_en     = slow_en_q;
    assign fast_rc_trim    = trim_q;
    assign fsys_en         = (mode_q == dcpm_pkg::DCPM_FAST) ? 1'b1 :
                             (mode_q == dcpm_pkg::DCPM_SLOW) ? slow_tick : 1'b0;
    assign periph_clk_en   = fsys_en;
    assign interval_timer_clk_en = (mode_q == dcpm_pkg::DCPM_FAST && sysctl_q.interval_timer_clk_select) ?
                                   (it_div_q == 7'(dcpm_pkg::IT_SYS_DIV - 1)) : slow_tick;
    assign cpu_run         = (mode_q == dcpm_pkg::DCPM_FAST) || (mode_q == dcpm_pkg::DCPM_SLOW);
    assign mode            = mode_q;
    assign timeout_flag    = to_q;
    assign power_down_flag = pd_q;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_SLOW_AFTER_RESET: assert property (sys_rst_q |=> mode_q == dcpm_pkg::DCPM_SLOW && slow_en_q)
        else $error("Mode not slow after reset");
    AST_REGS_DEFAULT: assert property (sys_rst_q |=> system_clock_control_q == dcpm_pkg::SYSTEM_CLOCK_CONTROL_RST &&
                                       sysctl_q == dcpm_pkg::SYSCTL_RST && trim_q == dcpm_pkg::TRIM_RST)
        else $error("Registers not at default after reset");
    AST_PIN_RESET: assert property (pin_rst |=> sys_rst_q ##1 system_clock_control_q == dcpm_pkg::SYSTEM_CLOCK_CONTROL_RST)
        else $error("Pin reset did not restore control registers");
    AST_FLAGS_KEPT: assert property (pin_rst && !lvr_act && !wdt_ovf_q && !watchdog_clear_instr &&
                                     !sleep_ok |=> $stable(to_q) && $stable(pd_q))
        else $error("Pin reset changed status flags");
    AST_BOTH_SET_REJECTED: assert property (wr_fire && wlane_q && aw_idx_q == dcpm_pkg::IDX_SYSTEM_CLOCK_CONTROL &&
                                            wbyte_q[3] && wbyte_q[2] && !sys_rst_q |=> $stable(system_clock_control_q))
        else $error("Illegal clock control write accepted");
    AST_FAST_CLOCKS: assert property (mode_q == dcpm_pkg::DCPM_FAST |-> fsys_en && periph_clk_en && fast_en_q)
        else $error("Fast mode clocks missing");
    AST_STOP_SILENT: assert property (mode_q == dcpm_pkg::DCPM_STOP |->
                                      !fast_en_q && !slow_en_q && !fsys_en && !interval_timer_clk_en)
        else $error("Clock running in stop");
    AST_STOP_HOLD: assert property (mode_q == dcpm_pkg::DCPM_STOP && !ext_int_wake && !sys_rst_q
                                    |=> mode_q == dcpm_pkg::DCPM_STOP)
        else $error("Stop left without external interrupt");
    AST_IDLE_ENTRY: assert property (sleep_ok && !system_clock_control_q.slow_osc_stop && !sys_rst_q
                                     |=> mode_q == dcpm_pkg::DCPM_IDLE && !cpu_run)
        else $error("Sleep did not enter idle");
    AST_TIMEOUT_SET: assert property (wdt_ovf_q && !lvr_act |=> to_q && sys_reset)
        else $error("Time-out flag not set");
    AST_PD_SET: assert property (sleep_ok && !wdt_ovf_q && !lvr_act |=> pd_q && !to_q)
        else $error("Power-down flag not set by sleep");
    AST_TRIM_WRITE: assert property (wr_fire && wlane_q && aw_idx_q == dcpm_pkg::IDX_TRIM && !sys_rst_q
                                     |=> fast_rc_trim == $past(wbyte_q[5:0]))
        else $error("Trim not updated");
endmodule
`default_nettype wire

/* tb/dual_clock_power_mode_ctrl_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; $display("ERROR %0t got %h exp %h", $time, a, e); end end
module dual_clock_power_mode_ctrl_tb_top;
    localparam logic [33:0] FULL = 34'h3FFFFFFFF;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  ev = 4'h0;
    logic        pin_n = 1'b1, bank = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [33:0] eq[$], mq[$];
    logic [33:0] e, m;
    logic [7:0]  v;
    int          n_fail = 0, n_compared = 0;
    always #50 aclk = ~aclk;
    dcpm_ctrl #(.WDT_BASE_TICKS(4)) dcpm_ctrl_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .lv_below(4'h0), .ext_reset_pin_n(pin_n), .sleep_instr(ev[0]),
        .watchdog_clear_instr(ev[1]), .bank_select_bit0(bank), .ext_int_wake(ev[2]), .wakeup_timer_int(1'b0),
        .timer_int_wake(ev[3]), .sys_reset(), .pc_reset_vector(), .fast_osc_en(), .slow_osc_en(),
        .fast_rc_trim(), .fsys_en(), .periph_clk_en(), .interval_timer_clk_en(), .cpu_run(), .mode(),
        .timeout_flag(), .power_down_flag());
    // Read results are checked against the oldest expectation
    always @(posedge aclk)
        if (rvalid && rready)
        begin
            e = eq.pop_front();
            m = mq.pop_front();
            `CHK({rresp, rdata} & m, e)
        end
    task conclude;
        if (n_fail == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wt(ref logic s);
        for (int k = 0; k < 500; k++)
        begin
            if (s)
                return;
            @(negedge aclk);
        end
        n_fail++;
        conclude;
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        @(negedge aclk);
        wt(awready);
        wt(wready);
        @(posedge aclk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        wt(bvalid);
        @(posedge aclk);
        bready <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [33:0] x, input logic [33:0] mk);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        eq.push_back(x);
        mq.push_back(mk);
        @(negedge aclk);
        wt(arready);
        @(posedge aclk);
        arvalid <= 1'b0;
        wt(rvalid);
        @(posedge aclk);
        rready <= 1'b0;
    endtask
    task st(input logic [7:0] x, input logic [7:0] mk);
        rd(12'h088, {26'h0, x}, {26'h3FFFFFF, mk});
    endtask
    task pulse(input logic [3:0] p);
        @(posedge aclk);
        ev <= p;
        @(posedge aclk);
        ev <= 4'h0;
    endtask
    task pin;
        pin_n <= 1'b0;
        repeat (300) @(posedge aclk);
        pin_n <= 1'b1;
        repeat (20) @(posedge aclk);
    endtask
    initial
    begin
        v = $urandom(15);
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        st(8'h82, 8'hBF);
        rd(12'h63C, 34'h20, FULL);
        rd(12'h000, {2'h2, 32'h0}, FULL);
        v = $urandom & 8'h3F;
        wr(12'h63C, v);
        rd(12'h63C, {26'h0, v}, FULL);
        wr(12'h02C, 8'h0C);
        rd(12'h02C, 34'h0, FULL);
        bank <= 1'b1;
        pulse(4'h1);
        st(8'h02, 8'h1F);
        bank <= 1'b0;
        pulse(4'h1);
        st(8'h14, 8'h1F);
        pulse(4'h8);
        st(8'h12, 8'h1F);
        pulse(4'h2);
        st(8'h02, 8'h1F);
        wr(12'h02C, 8'h04);
        st(8'h01, 8'h1F);
        wr(12'h02C, 8'h14);
        pulse(4'h1);
        st(8'h18, 8'h1F);
        pulse(4'h8);
        st(8'h18, 8'h1F);
        pulse(4'h4);
        st(8'h11, 8'h1F);
        pin;
        st(8'h11, 8'h1F);
        wr(12'h080, 8'h01);
        pin;
        st(8'h12, 8'h1F);
        rd(12'h63C, 34'h20, FULL);
        wr(12'h02C, 8'h04);
        wr(12'h02C, 8'h00);
        wr(12'h02C, 8'h08);
        st(8'h12, 8'h5F);
        wr(12'h080, 8'h05);
        repeat (700) @(posedge aclk);
        st(8'h32, 8'h3F);
        conclude;
    end
endmodule
`default_nettype wire
